/* File: hw/mailbox_regs.svh */
// Register selects, field positions and reset values
`ifndef MAILBOX_REGS_SVH
`define MAILBOX_REGS_SVH

// ==========================================================
// Core-side register selects
`define CORE_SEL_BYTE0      3'h0
`define CORE_SEL_BYTE1      3'h1
`define CORE_SEL_BYTE2      3'h2
`define CORE_SEL_FLAGS      3'h3
`define CORE_SEL_CTRL       3'h4

// ==========================================================
// Host-side register select of the flag register
`define HOST_SEL_FLAGS      2'h3

// ==========================================================
// Control register field positions
`define CTRL_IGNORE_MODE    7
`define CTRL_MODE_HI        6
`define CTRL_MODE_LO        5
`define CTRL_ENABLE         3
`define CTRL_DIR            2
`define CTRL_PRIO_HI        1
`define CTRL_PRIO_LO        0
`define CTRL_RESET          8'h00

// ==========================================================
// Boot strap code (hi,lo) that starts a cold boot over the port
`define BOOT_MODE_CODE      2'h1

// ==========================================================
// Flag register bit positions
`define FLAG_IN0            0
`define FLAG_IN_IRQ         1
`define FLAG_OUT0           2
`define FLAG_ATTN           3
`define FLAG_IN1            4
`define FLAG_IN2            5
`define FLAG_OUT1           6
`define FLAG_OUT2           7

`endif

/* File: hw/mailbox_pkg.sv */
// Types shared by the parallel mailbox port modules
package mailbox_pkg;
    typedef logic [7:0] byte_type;
    typedef logic [1:0] byte_idx_type;
    typedef enum {PHASE_IDLE, PHASE_READ, PHASE_WRITE} host_phase_type;
endpackage

/* File: hw/mailbox_store_if.sv */
// Interface between the mailbox port control and its byte store
`timescale 1ns/1ps
`default_nettype none
interface mailbox_store_if;
    import mailbox_pkg::*;
    logic         in_we;
    byte_idx_type in_idx;
    byte_type     in_wdata;
    logic         out_we;
    byte_idx_type out_idx;
    byte_type     out_wdata;
    byte_idx_type core_idx;
    byte_type     core_rdata;
    byte_idx_type host_idx;
    byte_type     host_rdata;

    modport store (input in_we, in_idx, in_wdata, out_we, out_idx, out_wdata,
                   input core_idx, host_idx, output core_rdata, host_rdata);
    modport ctrl  (output in_we, in_idx, in_wdata, out_we, out_idx, out_wdata,
                   output core_idx, host_idx, input core_rdata, host_rdata);
endinterface
`default_nettype wire

/* File: hw/mailbox_store.sv */
// Byte store of the inbound and outbound mailbox bytes
`timescale 1ns/1ps
`default_nettype none
module mailbox_store
    import mailbox_pkg::*;
(
    // Clock and reset
    input  wire logic      clk_sys,
    input  wire logic      rst_n,
    // Store port
    mailbox_store_if.store st
);

    byte_type in_mem  [3];
    byte_type out_mem [3];
    byte_type core_rdata_reg;
    byte_type host_rdata_reg;

    // ==========================================================
    // Writes from each side and registered reads
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 3; i++) begin
                in_mem[i]  <= 8'h00;
                out_mem[i] <= 8'h00;
            end
            core_rdata_reg <= 8'h00;
            host_rdata_reg <= 8'h00;
        end else begin
            if (st.in_we && st.in_idx != 2'h3) begin
                in_mem[st.in_idx] <= st.in_wdata;
            end
            if (st.out_we && st.out_idx != 2'h3) begin
                out_mem[st.out_idx] <= st.out_wdata;
            end
            core_rdata_reg <= (st.core_idx == 2'h3) ? 8'h00 : in_mem[st.core_idx];
            host_rdata_reg <= (st.host_idx == 2'h3) ? 8'h00 : out_mem[st.host_idx];
        end
    end

    assign st.core_rdata = core_rdata_reg;
    assign st.host_rdata = host_rdata_reg;

endmodule
`default_nettype wire

/* File: hw/slave_parallel_mailbox_port.sv */
// Slave-side parallel mailbox port
//
// Overview of operation
// - Three inbound and three outbound byte registers.
// - Full flag set on write, cleared on read.
// - Flag register readable by core and host.
// - Host write byte zero sets core interrupt.
// - Core write byte zero drives attention low.
// - Flag register write clears writer's interrupt source.
// - Host flag register write releases attention.
// - Drive data only during selected read.
// - Two select inputs choose host register.
// - Strobes ignored while select is high.
// - Selected read places register on data.
// - Write latches on write strobe rising edge.
// - After reset, port idle unless boot straps.
// - Enable code hands pins to port.
// - Enable bit, else direction bit selects.
// - Two-bit priority, zero disables interrupt.
// - Cold boot sets the enable bit.
// - Host sees bytes 0-2, flags 3.
`timescale 1ns/1ps
`default_nettype none
`include "mailbox_regs.svh"
module slave_parallel_mailbox_port
    import mailbox_pkg::*;
#(
    parameter int SYNC_STAGES = 2
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // Host bus pins
    input  wire logic       host_select_n,
    input  wire logic       host_read_strobe_n,
    input  wire logic       host_write_strobe_n,
    input  wire logic       reg_select_hi,
    input  wire logic       reg_select_lo,
    input  wire logic [7:0] host_data_lines_in,
    output logic      [7:0] host_data_lines_out,
    output logic            host_data_lines_oe,
    output logic            attention_to_master_n,
    // Boot strap pins
    input  wire logic       boot_mode_pin_hi,
    input  wire logic       boot_mode_pin_lo,
    output logic            cold_boot_active,
    // Core register access
    input  wire logic       core_wr,
    input  wire logic       core_rd,
    input  wire logic [2:0] core_sel,
    input  wire logic [7:0] core_wdata,
    output logic      [7:0] core_rdata,
    output logic            core_rvalid,
    // Core status and pin ownership
    output logic            slave_port_irq,
    output logic      [1:0] irq_priority,
    output logic            port_enable,
    output logic            parallel_dir_out
);

    if (SYNC_STAGES < 2) begin : g_bad_sync
        $error("SYNC_STAGES must be at least 2");
    end

    localparam int IN_W = 13;

    function automatic logic set_wins(input logic cur, input logic set, input logic clr);
        set_wins = set | (cur & ~clr);
    endfunction

    function automatic logic is_byte(input logic [2:0] sel);
        is_byte = (sel <= `CORE_SEL_BYTE2);
    endfunction

    mailbox_store_if st_if ();

    logic [IN_W-1:0] sync_reg [SYNC_STAGES];
    host_phase_type  phase_reg, phase_next;
    byte_idx_type    acc_idx_reg;
    byte_type        wr_hold_reg;
    logic [2:0]      in_full_reg, out_full_reg;
    logic            in_irq_reg, attn_n_reg;
    byte_type        ctrl_reg;
    logic            boot_seen_reg, cold_boot_reg;
    logic            rd_pend_reg;
    logic [2:0]      rd_sel_reg;
    byte_type        core_rdata_reg, host_out_reg;
    logic            core_rvalid_reg, oe_reg, irq_reg;

    // ==========================================================
    // Host pin synchronisation
    wire logic [IN_W-1:0] pins_raw = {host_select_n, host_read_strobe_n, host_write_strobe_n,
                                      reg_select_hi, reg_select_lo, host_data_lines_in};
    wire logic [IN_W-1:0] pins_s   = sync_reg[SYNC_STAGES-1];

    // Shift chain; each stage but the last is read only by the next stage
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < SYNC_STAGES; i++) begin
                sync_reg[i] <= 13'h1c00;
            end
        end else begin
            sync_reg[0] <= pins_raw;
            for (int i = 1; i < SYNC_STAGES; i++) begin
                sync_reg[i] <= sync_reg[i-1];
            end
        end
    end

    // ==========================================================
    // Host access decode
    wire logic         sel_s   = ~pins_s[12] & ctrl_reg[`CTRL_ENABLE];
    wire logic         h_rd    = sel_s & ~pins_s[11];
    wire logic         h_wr    = sel_s & ~pins_s[10];
    wire byte_idx_type addr_s  = pins_s[9:8];
    wire byte_type     data_s  = pins_s[7:0];
    wire logic         wr_done = (phase_reg == PHASE_WRITE) && !h_wr;
    wire logic         rd_done = (phase_reg == PHASE_READ) && !h_rd;
    wire logic         h_wr_byte  = wr_done && (acc_idx_reg != `HOST_SEL_FLAGS);
    wire logic         h_wr_flags = wr_done && (acc_idx_reg == `HOST_SEL_FLAGS);
    wire logic         h_rd_byte  = rd_done && (acc_idx_reg != `HOST_SEL_FLAGS);

    // Access phase tracking
    always_comb begin
        phase_next = phase_reg;
        case (phase_reg)
            PHASE_IDLE: begin
                if (h_wr) begin
                    phase_next = PHASE_WRITE;
                end else if (h_rd) begin
                    phase_next = PHASE_READ;
                end
            end
            PHASE_WRITE: if (!h_wr) phase_next = PHASE_IDLE;
            PHASE_READ:  if (!h_rd) phase_next = PHASE_IDLE;
            default:     phase_next = PHASE_IDLE;
        endcase
    end

    // Phase, access address and held write data
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg   <= PHASE_IDLE;
            acc_idx_reg <= 2'h0;
            wr_hold_reg <= 8'h00;
        end else begin
            phase_reg <= phase_next;
            if (phase_reg == PHASE_IDLE) begin
                acc_idx_reg <= addr_s;
            end
            if (h_wr) begin
                wr_hold_reg <= data_s;
            end
        end
    end

    // ==========================================================
    // Core access decode
    wire logic [1:0] core_idx   = core_sel[1:0];
    wire logic       c_wr_byte  = core_wr && is_byte(core_sel);
    wire logic       c_rd_byte  = core_rd && is_byte(core_sel);
    wire logic       c_wr_flags = core_wr && (core_sel == `CORE_SEL_FLAGS);
    wire logic       c_wr_ctrl  = core_wr && (core_sel == `CORE_SEL_CTRL);
    wire logic       c_wr_zero  = core_wr && (core_sel == `CORE_SEL_BYTE0);
    wire logic       h_wr_zero  = h_wr_byte && (acc_idx_reg == 2'h0);

    // Store connections
    assign st_if.in_we     = h_wr_byte;
    assign st_if.in_idx    = acc_idx_reg;
    assign st_if.in_wdata  = wr_hold_reg;
    assign st_if.out_we    = c_wr_byte;
    assign st_if.out_idx   = core_idx;
    assign st_if.out_wdata = core_wdata;
    assign st_if.core_idx  = core_idx;
    assign st_if.host_idx  = addr_s;

    // ==========================================================
    // Flags and handshakes, setting wins over clearing
    wire logic [7:0] flags_w;
    assign flags_w[`FLAG_IN0]    = in_full_reg[0];
    assign flags_w[`FLAG_IN_IRQ] = in_irq_reg;
    assign flags_w[`FLAG_OUT0]   = out_full_reg[0];
    assign flags_w[`FLAG_ATTN]   = ~attn_n_reg;
    assign flags_w[`FLAG_IN1]    = in_full_reg[1];
    assign flags_w[`FLAG_IN2]    = in_full_reg[2];
    assign flags_w[`FLAG_OUT1]   = out_full_reg[1];
    assign flags_w[`FLAG_OUT2]   = out_full_reg[2];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            in_full_reg  <= 3'h0;
            out_full_reg <= 3'h0;
            in_irq_reg   <= 1'b0;
            attn_n_reg   <= 1'b1;
        end else begin
            for (int i = 0; i < 3; i++) begin
                in_full_reg[i]  <= set_wins(in_full_reg[i],
                                   h_wr_byte && acc_idx_reg == 2'(i),
                                   c_rd_byte && core_idx == 2'(i));
                out_full_reg[i] <= set_wins(out_full_reg[i],
                                   c_wr_byte && core_idx == 2'(i),
                                   h_rd_byte && acc_idx_reg == 2'(i));
            end
            in_irq_reg <= set_wins(in_irq_reg, h_wr_zero, c_wr_flags);
            attn_n_reg <= ~set_wins(~attn_n_reg, c_wr_zero, h_wr_flags);
        end
    end

    // ==========================================================
    // Control register and boot straps
    wire logic [1:0] mode_pins = {boot_mode_pin_hi, boot_mode_pin_lo};
    wire logic       boot_hit  = (mode_pins == `BOOT_MODE_CODE) && !ctrl_reg[`CTRL_IGNORE_MODE];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg      <= `CTRL_RESET;
            boot_seen_reg <= 1'b0;
            cold_boot_reg <= 1'b0;
        end else begin
            boot_seen_reg <= 1'b1;
            if (c_wr_ctrl) begin
                ctrl_reg <= core_wdata & 8'h8f;
            end else if (!boot_seen_reg && boot_hit) begin
                ctrl_reg[`CTRL_ENABLE] <= 1'b1;
            end
            if (!boot_seen_reg) begin
                cold_boot_reg <= boot_hit;
            end else if (!boot_hit) begin
                cold_boot_reg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Output registers
    wire byte_type ctrl_view = {ctrl_reg[7], mode_pins, 1'b0, ctrl_reg[3:0]};
    wire byte_type core_mux  = is_byte(rd_sel_reg) ? st_if.core_rdata :
                               (rd_sel_reg == `CORE_SEL_FLAGS) ? flags_w :
                               (rd_sel_reg == `CORE_SEL_CTRL) ? ctrl_view : 8'h00;
    wire byte_type host_mux  = (addr_s == `HOST_SEL_FLAGS) ? flags_w : st_if.host_rdata;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_pend_reg     <= 1'b0;
            rd_sel_reg      <= 3'h0;
            core_rdata_reg  <= 8'h00;
            core_rvalid_reg <= 1'b0;
            host_out_reg    <= 8'h00;
            oe_reg          <= 1'b0;
            irq_reg         <= 1'b0;
        end else begin
            rd_pend_reg     <= core_rd;
            rd_sel_reg      <= core_sel;
            core_rvalid_reg <= rd_pend_reg;
            if (rd_pend_reg) begin
                core_rdata_reg <= core_mux;
            end
            host_out_reg <= host_mux;
            oe_reg       <= h_rd;
            irq_reg      <= in_irq_reg && (ctrl_reg[1:0] != 2'h0);
        end
    end

    mailbox_store u_store (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .st      (st_if.store)
    );

    assign host_data_lines_out   = host_out_reg;
    assign host_data_lines_oe    = oe_reg;
    assign attention_to_master_n = attn_n_reg;
    assign cold_boot_active      = cold_boot_reg;
    assign core_rdata            = core_rdata_reg;
    assign core_rvalid           = core_rvalid_reg;
    assign slave_port_irq        = irq_reg;
    assign irq_priority          = ctrl_reg[1:0];
    assign port_enable           = ctrl_reg[`CTRL_ENABLE];
    assign parallel_dir_out      = ~ctrl_reg[`CTRL_ENABLE] & ctrl_reg[`CTRL_DIR];

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_host_write;
        h_wr ##1 !h_wr;
    endsequence
    sequence s_boot_start;
        !boot_seen_reg && boot_hit && !c_wr_ctrl;
    endsequence

    property p_drive_only_read;
        host_data_lines_oe |-> $past(h_rd);
    endproperty
    a_drive_only_read: assert property (p_drive_only_read) else $error("data driven outside read");

    property p_disabled_quiet;
        !port_enable ##1 !port_enable |=> !host_data_lines_oe;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("data driven while disabled");

    property p_unselected_ignored;
        (pins_s[12] && phase_reg == PHASE_IDLE) |=> !st_if.in_we;
    endproperty
    a_unselected_ignored: assert property (p_unselected_ignored) else $error("strobe taken unselected");

    property p_write_commits;
        s_host_write |-> (acc_idx_reg == `HOST_SEL_FLAGS || st_if.in_we);
    endproperty
    a_write_commits: assert property (p_write_commits) else $error("host write not stored");

    property p_full_set;
        h_wr_byte |=> in_full_reg[$past(acc_idx_reg)];
    endproperty
    a_full_set: assert property (p_full_set) else $error("inbound full flag not set");

    property p_full_clear;
        (c_rd_byte && !(h_wr_byte && acc_idx_reg == core_idx)) |=> !in_full_reg[$past(core_idx)];
    endproperty
    a_full_clear: assert property (p_full_clear) else $error("inbound full flag not cleared");

    property p_irq_raise;
        h_wr_zero ##1 (ctrl_reg[1:0] != 2'h0) |=> slave_port_irq;
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("core interrupt not raised");

    property p_irq_masked;
        (ctrl_reg[1:0] == 2'h0) |=> !slave_port_irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("interrupt with zero priority");

    property p_core_clear;
        (c_wr_flags && !h_wr_zero) |=> !in_irq_reg;
    endproperty
    a_core_clear: assert property (p_core_clear) else $error("flag write kept interrupt");

    property p_attn_low;
        c_wr_zero |=> !attention_to_master_n;
    endproperty
    a_attn_low: assert property (p_attn_low) else $error("attention not asserted");

    property p_attn_release;
        (h_wr_flags && !c_wr_zero) |=> attention_to_master_n;
    endproperty
    a_attn_release: assert property (p_attn_release) else $error("attention not released");

    property p_boot_enable;
        s_boot_start |=> (port_enable && cold_boot_active);
    endproperty
    a_boot_enable: assert property (p_boot_enable) else $error("cold boot did not enable port");

endmodule
`default_nettype wire

/* File: tb/host_master_model.sv */
// External master model driving the host bus pins
`timescale 1ns/1ps
`default_nettype none
module host_master_model
    import mailbox_pkg::*;
(
    // Clock
    input  wire logic       clk_sys,
    // Host bus pins
    output logic            host_select_n,
    output logic            host_read_strobe_n,
    output logic            host_write_strobe_n,
    output logic            reg_select_hi,
    output logic            reg_select_lo,
    output logic      [7:0] host_data_lines_in,
    input  wire logic [7:0] host_data_lines_out,
    input  wire logic       host_data_lines_oe
);
    logic     drive;
    byte_type drive_data;
    byte_type idle_data;

    // ==========================================================
    // Shared wire; released it shows the last written byte inverted
    assign host_data_lines_in = host_data_lines_oe ? host_data_lines_out
                              : (drive ? drive_data : idle_data);

    // Idle bus, address always driven
    initial begin
        host_select_n = 1'b1;
        host_read_strobe_n = 1'b1;
        host_write_strobe_n = 1'b1;
        reg_select_hi = 1'b0;
        reg_select_lo = 1'b0;
        drive = 1'b0;
        idle_data = 8'hff;
    end

    // Address and select lead the strobe by 3 cycles
    task automatic bus_start(input logic [1:0] addr, input logic sel);
        @(posedge clk_sys);
        reg_select_hi <= addr[1];
        reg_select_lo <= addr[0];
        host_select_n <= ~sel;
        repeat (3) @(posedge clk_sys);
    endtask

    // One write; sel low leaves the select high
    task automatic write_cycle(input logic [1:0] addr, input byte_type d, input logic sel);
        drive_data <= d;
        drive <= 1'b1;
        bus_start(addr, sel);
        host_write_strobe_n <= 1'b0;
        repeat (5) @(posedge clk_sys);
        host_write_strobe_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        host_select_n <= 1'b1;
        drive <= 1'b0;
        idle_data <= ~d;
        repeat (6) @(posedge clk_sys);
    endtask

    // One read; returns data and the enable mid and after
    task automatic read_cycle(input logic [1:0] addr, input logic sel, output byte_type d,
                              output logic oe_mid, output logic oe_end);
        bus_start(addr, sel);
        host_read_strobe_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        d = host_data_lines_in;
        oe_mid = host_data_lines_oe;
        host_read_strobe_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        host_select_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        oe_end = host_data_lines_oe;
    endtask
endmodule
`default_nettype wire

/* File: tb/test_slave_parallel_mailbox_port.sv */
// Self-checking testbench of the slave parallel mailbox port
`timescale 1ns/1ps
`default_nettype none
`include "mailbox_regs.svh"
module test_slave_parallel_mailbox_port;
    import mailbox_pkg::*;
    logic       clk_sys, rst_n, host_select_n, host_read_strobe_n, host_write_strobe_n;
    logic       reg_select_hi, reg_select_lo, host_data_lines_oe, attention_to_master_n;
    logic       boot_mode_pin_hi, boot_mode_pin_lo, cold_boot_active, core_wr, core_rd;
    logic       core_rvalid, slave_port_irq, port_enable, parallel_dir_out, in_irq, attn;
    logic       oe_mid, oe_end;
    logic [7:0] host_data_lines_in, host_data_lines_out, core_wdata, core_rdata, ctrl;
    logic [2:0] core_sel, in_full, out_full;
    logic [1:0] irq_priority;
    byte_type   in_b[3], out_b[3], rd_val, wr_val;
    int         num_errors, total_checks, seed;

    // ==========================================================
    // Design and external master
    slave_parallel_mailbox_port i_slave_parallel_mailbox_port (.clk_sys, .rst_n,
        .host_select_n, .host_read_strobe_n, .host_write_strobe_n, .reg_select_hi,
        .reg_select_lo, .host_data_lines_in, .host_data_lines_out, .host_data_lines_oe,
        .attention_to_master_n, .boot_mode_pin_hi, .boot_mode_pin_lo, .cold_boot_active,
        .core_wr, .core_rd, .core_sel, .core_wdata, .core_rdata, .core_rvalid,
        .slave_port_irq, .irq_priority, .port_enable, .parallel_dir_out);
    host_master_model i_host_master_model (.clk_sys, .host_select_n, .host_read_strobe_n,
        .host_write_strobe_n, .reg_select_hi, .reg_select_lo, .host_data_lines_in,
        .host_data_lines_out, .host_data_lines_oe);

    // Clock and watchdog
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        #900000;
        $display("[FAIL] %0t run timeout", $time);
        num_errors++;
        end_of_test();
    end

    // ==========================================================
    // Compare helpers and model
    task automatic compare_byte(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t byte got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic compare_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t bit got %b expected %b", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] model_flags();
        return {out_full[2], out_full[1], in_full[2], in_full[1], attn, out_full[0], in_irq,
                in_full[0]};
    endfunction
    function automatic logic [7:0] ctrl_read();
        return {ctrl[7], boot_mode_pin_hi, boot_mode_pin_lo, 1'b0, ctrl[3:0]};
    endfunction
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Reset with straps set; the model follows
    task automatic model_reset(input logic hi, input logic lo);
        in_full = 3'h0;
        out_full = 3'h0;
        in_irq = 1'b0;
        attn = 1'b0;
        ctrl = (hi == 1'b0 && lo == 1'b1) ? 8'h08 : 8'h00;
        boot_mode_pin_hi <= hi;
        boot_mode_pin_lo <= lo;
        rst_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
    endtask

    // Pin outputs against the model
    task automatic check_pins();
        repeat (3) @(posedge clk_sys);
        #1;
        compare_bit(attention_to_master_n, ~attn);
        compare_bit(slave_port_irq, in_irq & (ctrl[1:0] != 2'b00));
        compare_bit(port_enable, ctrl[3]);
        compare_bit(parallel_dir_out, ~ctrl[3] & ctrl[2]);
        compare_byte({6'h00, irq_priority}, {6'h00, ctrl[1:0]});
    endtask

    // Core register access
    task automatic core_write(input logic [2:0] sel, input byte_type d);
        @(posedge clk_sys);
        core_wr <= 1'b1;
        core_sel <= sel;
        core_wdata <= d;
        @(posedge clk_sys);
        core_wr <= 1'b0;
    endtask
    task automatic core_check(input logic [2:0] sel, input byte_type exp);
        int n;
        @(posedge clk_sys);
        core_rd <= 1'b1;
        core_sel <= sel;
        @(posedge clk_sys);
        core_rd <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (core_rvalid !== 1'b1 && n < 4);
        if (core_rvalid !== 1'b1) begin
            $display("[FAIL] %0t no core read answer", $time);
            num_errors++;
            end_of_test();
        end
        compare_byte(core_rdata, exp);
    endtask

    // Host read with enable checks
    task automatic host_check(input logic [1:0] a, input byte_type exp, input logic sel);
        i_host_master_model.read_cycle(a, sel, rd_val, oe_mid, oe_end);
        compare_bit(oe_mid, sel);
        compare_bit(oe_end, 1'b0);
        if (sel) compare_byte(rd_val, exp);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        seed = 44;
        rst_n = 1'b0;
        core_wr = 1'b0;
        core_rd = 1'b0;
        core_sel = 3'h0;
        core_wdata = 8'h00;
        model_reset(1'b0, 1'b0);
        check_pins();
        i_host_master_model.write_cycle(2'h0, 8'h5a, 1'b1);
        core_check(`CORE_SEL_FLAGS, model_flags());
        core_check(`CORE_SEL_CTRL, ctrl_read());
        $display("test reset done");
        // Direction, ignore bit and every priority code
        for (int p = 0; p < 4; p++) begin
            wr_val = 8'hf4 | p[7:0];
            core_write(`CORE_SEL_CTRL, wr_val);
            ctrl = wr_val & 8'h8f;
            check_pins();
            core_check(`CORE_SEL_CTRL, ctrl_read());
        end
        core_write(`CORE_SEL_CTRL, 8'h08);
        ctrl = 8'h08;
        check_pins();
        $display("test control done");
        // Inbound bytes, unselected strobe, gated interrupt
        for (int k = 0; k < 3; k++) begin
            in_b[k] = byte_type'($random(seed));
            i_host_master_model.write_cycle(k[1:0], in_b[k], 1'b1);
            in_full[k] = 1'b1;
        end
        in_irq = 1'b1;
        i_host_master_model.write_cycle(2'h1, ~in_b[1], 1'b0);
        check_pins();
        core_check(`CORE_SEL_FLAGS, model_flags());
        core_write(`CORE_SEL_CTRL, 8'h0a);
        ctrl = 8'h0a;
        check_pins();
        for (int k = 0; k < 3; k++) begin
            core_check(k[2:0], in_b[k]);
            in_full[k] = 1'b0;
        end
        core_check(`CORE_SEL_FLAGS, model_flags());
        core_write(`CORE_SEL_FLAGS, 8'hff);
        in_irq = 1'b0;
        check_pins();
        core_check(`CORE_SEL_FLAGS, model_flags());
        $display("test inbound done");
        // Outbound bytes, attention, host side
        for (int k = 0; k < 3; k++) begin
            out_b[k] = byte_type'($random(seed));
            core_write(k[2:0], out_b[k]);
            out_full[k] = 1'b1;
        end
        attn = 1'b1;
        check_pins();
        host_check(`HOST_SEL_FLAGS, model_flags(), 1'b1);
        for (int k = 0; k < 3; k++) begin
            host_check(k[1:0], out_b[k], 1'b1);
            out_full[k] = 1'b0;
        end
        host_check(`HOST_SEL_FLAGS, model_flags(), 1'b1);
        host_check(2'h0, 8'h00, 1'b0);
        i_host_master_model.write_cycle(`HOST_SEL_FLAGS, 8'hff, 1'b1);
        attn = 1'b0;
        check_pins();
        core_check(`CORE_SEL_CTRL, ctrl_read());
        $display("test outbound done");
        // Cold boot through a second reset
        model_reset(1'b0, 1'b1);
        check_pins();
        compare_bit(cold_boot_active, 1'b1);
        core_check(`CORE_SEL_CTRL, ctrl_read());
        i_host_master_model.write_cycle(2'h0, 8'ha5, 1'b1);
        in_full[0] = 1'b1;
        in_irq = 1'b1;
        core_check(`CORE_SEL_FLAGS, model_flags());
        boot_mode_pin_lo <= 1'b0;
        check_pins();
        compare_bit(cold_boot_active, 1'b0);
        $display("test cold boot done");
        end_of_test();
    end
endmodule
`default_nettype wire
